// File: core/lspseq_pkg.sv
// constants and state type for the led string protection sequencer
package lspseq_pkg;
  // system clock rate
  localparam int CLK_SYS_HZ        = 40000000;
  // open-string persistence before forced dimming, in ns
  localparam int FORCE_DIM_TIME_NS = 5000;
  localparam int FORCE_DIM_CYCLES  = (FORCE_DIM_TIME_NS * (CLK_SYS_HZ / 1000000) + 999) / 1000;
  // over-current delay before gate shutdown, in ns
  localparam int OCP_DELAY_TIME_NS = 1000;
  localparam int OCP_DELAY_CYCLES  = (OCP_DELAY_TIME_NS * (CLK_SYS_HZ / 1000000) + 999) / 1000;
  // counts in boost oscillator periods
  localparam int BLANK_OSC_PERIODS = 8192;
  localparam int AUTO_RESTART_PERIODS = 128;
  // counter widths
  localparam int US_CNT_W          = 8;
  localparam int OSC_CNT_W         = 14;
  // over-current sequence states
  typedef enum logic [2:0] {
    OC_RUN   = 3'b001,
    OC_DELAY = 3'b010,
    OC_OFF   = 3'b100
  } lspseq_oc_state_t;
endpackage

// File: core/lspseq_sync.sv
// three-stage synchroniser with agreement filter
`timescale 1ns/100ps
module lspseq_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // async level in, filtered level out
  input  wire logic din,
  output logic      dout
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1   <= 1'b0;
      s2   <= 1'b0;
      s3   <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      // change only once stages two and three agree
      if (s2 == s3) begin
        dout <= s3;
      end
    end
  end
endmodule

// File: core/lspseq_top.sv
// protection sequencer for a single-string led boost driver
`timescale 1ns/100ps
module lspseq_top (
  // clock and reset
  input  wire logic CLK_SYS,
  input  wire logic RST,
  // enable and supply comparators
  input  wire logic CHIP_ENABLE_INPUT,
  input  wire logic SUPPLY_OK,
  // dimming and oscillator
  input  wire logic PULSE_DIMMING_INPUT,
  input  wire logic OSC_TICK,
  // comparator results
  input  wire logic FB_BELOW_OPEN,
  input  wire logic OV_TRIP_ABOVE,
  input  wire logic OV_RELEASE_BELOW,
  input  wire logic LED_OVERCURRENT_PROTECT,
  // switch drive
  output logic      BOOST_GATE_EN,
  output logic      DIM_GATE_EN,
  output logic      ERRAMP_CONNECT,
  // fault pin, open drain
  output logic      FAULT_O,
  output logic      FAULT_OE,
  // status
  output logic      OUTPUT_OVERVOLTAGE_PROTECT,
  output logic      OPEN_FAULT
);
  ////////////////////////////////////////////////////////////////////////
  logic en_s, sup_s, dim_s, osc_s, fbl_s, ovt_s, ovr_s, oc_s;
  lspseq_sync u_en  (.clk(CLK_SYS), .rst(RST), .din(CHIP_ENABLE_INPUT),       .dout(en_s));
  lspseq_sync u_sup (.clk(CLK_SYS), .rst(RST), .din(SUPPLY_OK),               .dout(sup_s));
  lspseq_sync u_dim (.clk(CLK_SYS), .rst(RST), .din(PULSE_DIMMING_INPUT),     .dout(dim_s));
  lspseq_sync u_osc (.clk(CLK_SYS), .rst(RST), .din(OSC_TICK),                .dout(osc_s));
  lspseq_sync u_fbl (.clk(CLK_SYS), .rst(RST), .din(FB_BELOW_OPEN),           .dout(fbl_s));
  lspseq_sync u_ovt (.clk(CLK_SYS), .rst(RST), .din(OV_TRIP_ABOVE),           .dout(ovt_s));
  lspseq_sync u_ovr (.clk(CLK_SYS), .rst(RST), .din(OV_RELEASE_BELOW),        .dout(ovr_s));
  lspseq_sync u_oc  (.clk(CLK_SYS), .rst(RST), .din(LED_OVERCURRENT_PROTECT), .dout(oc_s));

  ////////////////////////////////////////////////////////////////////////
  logic osc_d;
  logic armed;
  logic force_dim;
  logic fault;
  logic ov;
  logic [lspseq_pkg::US_CNT_W-1:0]  open_us_cnt;
  logic [lspseq_pkg::OSC_CNT_W-1:0] blank_cnt;
  logic [lspseq_pkg::US_CNT_W-1:0]  oc_dly_cnt;
  logic [lspseq_pkg::OSC_CNT_W-1:0] ar_cnt;
  lspseq_pkg::lspseq_oc_state_t oc_state;
  lspseq_pkg::lspseq_oc_state_t next_oc_state;

  wire run        = en_s & sup_s;
  wire osc_edge   = osc_s & ~osc_d;
  wire eff_dim    = dim_s | force_dim;
  // over-voltage masks the open check so it always acts first
  wire open_cond  = run & armed & eff_dim & fbl_s & ~ov;
  wire us_done    = open_us_cnt == lspseq_pkg::US_CNT_W'(lspseq_pkg::FORCE_DIM_CYCLES);
  wire blank_done = blank_cnt == lspseq_pkg::OSC_CNT_W'(lspseq_pkg::BLANK_OSC_PERIODS - 1);
  wire oc_dly_done = oc_dly_cnt == lspseq_pkg::US_CNT_W'(lspseq_pkg::OCP_DELAY_CYCLES - 1);
  wire ar_done    = ar_cnt == lspseq_pkg::OSC_CNT_W'(lspseq_pkg::AUTO_RESTART_PERIODS - 1);
  wire oc_off     = oc_state == lspseq_pkg::OC_OFF;
  wire gates_on   = run & eff_dim & ~ov & ~oc_off;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      osc_d <= 1'b0;
    end else begin
      osc_d <= osc_s;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      armed <= 1'b0;
    end else if (!run) begin
      armed <= 1'b0;
    end else if (dim_s) begin
      armed <= 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      open_us_cnt <= '0;
      force_dim   <= 1'b0;
    end else if (!open_cond) begin
      open_us_cnt <= '0;
      force_dim   <= 1'b0;
    end else if (!us_done) begin
      open_us_cnt <= open_us_cnt + 1'b1;
    end else begin
      force_dim <= 1'b1;
    end
  end

  // blanking counts only while the open condition holds
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      blank_cnt <= '0;
      fault     <= 1'b0;
    end else if (!run) begin
      blank_cnt <= '0;
      fault     <= 1'b0;
    end else if (!open_cond) begin
      blank_cnt <= '0;
    end else if (osc_edge) begin
      if (blank_done) begin
        fault <= 1'b1;
      end else begin
        blank_cnt <= blank_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ov <= 1'b0;
    end else if (!run) begin
      ov <= 1'b0;
    end else if (ovt_s) begin
      ov <= 1'b1;
    end else if (ovr_s) begin
      ov <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // threshold clamp of four times dimming level lives in the comparator
  always_comb begin
    next_oc_state = oc_state;
    unique case (oc_state)
      lspseq_pkg::OC_RUN: begin
        if (oc_s) next_oc_state = lspseq_pkg::OC_DELAY;
      end
      lspseq_pkg::OC_DELAY: begin
        if (oc_dly_done) next_oc_state = lspseq_pkg::OC_OFF;
      end
      lspseq_pkg::OC_OFF: begin
        if (osc_edge && ar_done) next_oc_state = lspseq_pkg::OC_RUN;
      end
      default: next_oc_state = lspseq_pkg::OC_RUN;
    endcase
    if (!run) next_oc_state = lspseq_pkg::OC_RUN;
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      oc_state   <= lspseq_pkg::OC_RUN;
      oc_dly_cnt <= '0;
      ar_cnt     <= '0;
    end else begin
      oc_state   <= next_oc_state;
      oc_dly_cnt <= (oc_state == lspseq_pkg::OC_DELAY) ? oc_dly_cnt + 1'b1 : '0;
      if (!oc_off) begin
        ar_cnt <= '0;
      end else if (osc_edge) begin
        ar_cnt <= ar_cnt + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      BOOST_GATE_EN  <= 1'b0;
      DIM_GATE_EN    <= 1'b0;
      ERRAMP_CONNECT <= 1'b0;
      FAULT_OE       <= 1'b1;
    end else begin
      BOOST_GATE_EN  <= gates_on;
      DIM_GATE_EN    <= gates_on;
      ERRAMP_CONNECT <= gates_on;
      FAULT_OE       <= ~fault;
    end
  end

  // pin only pulls low; pull-up gives the high level, system acts on it
  assign FAULT_O = 1'b0;
  assign OUTPUT_OVERVOLTAGE_PROTECT = ov;
  assign OPEN_FAULT = fault;

  ////////////////////////////////////////////////////////////////////////
  sequence s_oc_wait;
    oc_state == lspseq_pkg::OC_DELAY [*8];
  endsequence

  // independent run length of the open condition, saturating, for a_force
  logic [lspseq_pkg::US_CNT_W-1:0] open_run;
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      open_run <= '0;
    end else if (!open_cond) begin
      open_run <= '0;
    end else if (open_run != '1) begin
      open_run <= open_run + 1'b1;
    end
  end

  property p_arm;
    @(posedge CLK_SYS) disable iff (RST) !armed |=> !force_dim && !fault;
  endproperty
  a_arm: assert property (p_arm) else $error("open check before arming");

  property p_open;
    @(posedge CLK_SYS) disable iff (RST)
      (run && armed && dim_s && fbl_s && !ov) |=> open_us_cnt != '0;
  endproperty
  a_open: assert property (p_open) else $error("open condition missed");

  property p_force;
    @(posedge CLK_SYS) disable iff (RST)
      open_cond && open_run >= lspseq_pkg::US_CNT_W'(lspseq_pkg::FORCE_DIM_CYCLES)
      |=> force_dim;
  endproperty
  a_force: assert property (p_force) else $error("forced dimming late");

  property p_fault_src;
    @(posedge CLK_SYS) disable iff (RST) $rose(fault) |-> $past(open_cond) && $past(blank_done);
  endproperty
  a_fault_src: assert property (p_fault_src) else $error("fault without blanking");

  property p_pin;
    @(posedge CLK_SYS) disable iff (RST) fault |=> !FAULT_OE;
  endproperty
  a_pin: assert property (p_pin) else $error("fault pin not released");

  property p_pin_only;
    @(posedge CLK_SYS) disable iff (RST) !fault |=> FAULT_OE;
  endproperty
  a_pin_only: assert property (p_pin_only) else $error("fault pin from other source");

  property p_ov;
    @(posedge CLK_SYS) disable iff (RST) ov |=> !BOOST_GATE_EN && !DIM_GATE_EN;
  endproperty
  a_ov: assert property (p_ov) else $error("gates on in over-voltage");

  property p_ov_rel;
    @(posedge CLK_SYS) disable iff (RST)
      $fell(ov) && $past(run) |-> $past(ovr_s) && !$past(ovt_s);
  endproperty
  a_ov_rel: assert property (p_ov_rel) else $error("over-voltage released early");

  property p_oc;
    @(posedge CLK_SYS) disable iff (RST) $rose(oc_state == lspseq_pkg::OC_DELAY) && run
      ##0 s_oc_wait ##32 (run) |=> oc_off;
  endproperty
  a_oc: assert property (p_oc) else $error("over-current shutdown missing");

  property p_ov_first;
    @(posedge CLK_SYS) disable iff (RST) ov |=> !force_dim && blank_cnt == '0;
  endproperty
  a_ov_first: assert property (p_ov_first) else $error("open check during over-voltage");

  property p_dis;
    @(posedge CLK_SYS) disable iff (RST) !run |=> !fault && !force_dim && !armed;
  endproperty
  a_dis: assert property (p_dis) else $error("disable did not clear");
endmodule

// File: verification/lspseq_power_stage.sv
// boost power stage and system power controller model
`timescale 1ns/100ps
module lspseq_power_stage (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // fault pin drive from the block
  input  wire logic fault_o,
  input  wire logic fault_oe,
  // oscillator, pin level, power removal
  output logic      osc_tick,
  output logic      fault_pin,
  output logic      power_cut
);
  logic [1:0] div;
  // oscillator runs free; four clocks a period so the synchroniser sees each half
  assign osc_tick  = div[1];
  // pull-up to the reference when the pin is released
  assign fault_pin = fault_oe ? fault_o : 1'b1;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div       <= 2'h0;
      power_cut <= 1'b0;
    end else begin
      div <= div + 2'h1;
      // a released pin removes input power and stays latched
      if (fault_pin) begin
        power_cut <= 1'b1;
      end
    end
  end
endmodule

// File: verification/test_led_string_protection_sequencer.sv
// self-checking bench for the led string protection sequencer
`timescale 1ns/100ps
module test_led_string_protection_sequencer;
  logic CLK_SYS = 1'b0;
  logic RST     = 1'b1;
  logic en      = 1'b0;
  logic sok     = 1'b0;
  logic dim     = 1'b0;
  logic fbl     = 1'b0;
  logic ovt     = 1'b0;
  logic ovr     = 1'b1;
  logic oc      = 1'b0;
  logic d;
  logic boost, dimg, erramp, fo, foe, output_overvoltage_protect, ofault, osc, pin, cut;
  int   bad_count   = 0;
  int   comparisons = 0;
  int   n;

  always #12.5 CLK_SYS = ~CLK_SYS;

  lspseq_power_stage lspseq_power_stage_i (
    .clk(CLK_SYS), .rst(RST), .fault_o(fo), .fault_oe(foe),
    .osc_tick(osc), .fault_pin(pin), .power_cut(cut)
  );

  lspseq_top lspseq_top_i (
    .CLK_SYS(CLK_SYS), .RST(RST), .CHIP_ENABLE_INPUT(en), .SUPPLY_OK(sok),
    .PULSE_DIMMING_INPUT(dim), .OSC_TICK(osc), .FB_BELOW_OPEN(fbl),
    .OV_TRIP_ABOVE(ovt), .OV_RELEASE_BELOW(ovr), .LED_OVERCURRENT_PROTECT(oc),
    .BOOST_GATE_EN(boost), .DIM_GATE_EN(dimg), .ERRAMP_CONNECT(erramp),
    .FAULT_O(fo), .FAULT_OE(foe), .OUTPUT_OVERVOLTAGE_PROTECT(output_overvoltage_protect), .OPEN_FAULT(ofault)
  );

  ////////////////////////////////////////////////////////////////////////////
  // both gates follow plain dimming when no protection acts
  function automatic logic [1:0] gx(input logic v);
    return {v, v};
  endfunction

  task automatic cyc(input int k);
    repeat (k) @(negedge CLK_SYS);
  endtask

  task automatic chk(input logic [1:0] got, input logic [1:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h00d6a74c));
    cyc(2);
    RST = 1'b0;
    chk({boost, dimg}, 2'b00);
    chk({foe, fo}, 2'b10);
    cyc(1);
    // low feedback before any dimming high must be ignored
    en = 1'b1;
    sok = 1'b1;
    fbl = 1'b1;
    cyc(400);
    chk({dimg, ofault}, 2'b00);
    fbl = 1'b0;
    for (int i = 0; i < 12; i++) begin
      d = 1'($urandom_range(1, 0));
      dim = d;
      cyc(8);
      chk({boost, dimg}, gx(d));
      chk({erramp, erramp}, gx(d));
    end
    // over-voltage with an open string: no open-string action meanwhile
    dim = 1'b1;
    ovt = 1'b1;
    ovr = 1'b0;
    fbl = 1'b1;
    cyc(8);
    chk({output_overvoltage_protect, boost}, 2'b10);
    chk({dimg, foe}, 2'b01);
    ovt = 1'b0;
    cyc(400);
    chk({output_overvoltage_protect, ofault}, 2'b10);
    fbl = 1'b0;
    ovr = 1'b1;
    cyc(8);
    chk({output_overvoltage_protect, boost}, 2'b01);
    // over-current: gates stay on for the delay, then off until restart
    oc = 1'b1;
    cyc(30);
    chk({boost, dimg}, 2'b11);
    cyc(20);
    chk({boost, dimg}, 2'b00);
    chk({foe, ofault}, 2'b10);
    oc = 1'b0;
    cyc(400);
    chk({boost, dimg}, 2'b00);
    cyc(200);
    chk({boost, dimg}, 2'b11);
    // open string: forced dimming, then the fault after blanking
    fbl = 1'b1;
    cyc(260);
    dim = 1'b0;
    cyc(8);
    chk({dimg, ofault}, 2'b10);
    cyc(31000);
    chk({ofault, pin}, 2'b00);
    n = 0;
    while (ofault !== 1'b1 && n < 4000) begin
      cyc(1);
      n++;
    end
    if (ofault !== 1'b1) begin
      bad_count++;
      results();
    end
    cyc(2);
    chk({foe, pin}, 2'b01);
    chk({cut, ofault}, 2'b11);
    // disable clears everything; lockout stops the gates
    en = 1'b0;
    cyc(8);
    chk({ofault, foe}, 2'b01);
    chk({boost, dimg}, 2'b00);
    en = 1'b1;
    dim = 1'b1;
    fbl = 1'b0;
    cyc(8);
    chk({boost, dimg}, 2'b11);
    sok = 1'b0;
    cyc(8);
    chk({boost, dimg}, 2'b00);
    results();
  end
endmodule
